// File: rtl/srps_pkg.sv
// Purpose: Constants and types for the sequencer run/pause source select block
// Assumes: One clock pclk at 10 MHz, asynchronous active-low reset presetn
// Notes: Contract
package srps_pkg;
    localparam int DI_COUNT = 5;
    localparam int TF_COUNT = 4;
    localparam logic [11:0] OFS_CFG = 12'h000;
    localparam logic [11:0] OFS_FORCE = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam int CFG_ACT_POS = 0;
    localparam int CFG_HOLD_POS = 8;
    localparam int CFG_REW_POS = 16;
    localparam int CFG_PERMIT_POS = 24;
    localparam int STS_STEP_POS = 0;
    localparam int STS_STATE_POS = 8;
    localparam int STS_MOTOR_POS = 12;
    localparam int STS_TIMER_POS = 16;
    localparam logic signed [4:0] SEL_NONE = 5'sh00;
    localparam logic signed [4:0] ACT_MOTOR = 5'sh06;
    localparam logic signed [4:0] ACT_TF_FIRST = 5'sh07;
    localparam logic signed [4:0] ACT_ALWAYS = 5'sh0b;
    localparam logic signed [4:0] HOLD_ALWAYS = 5'sh06;
    localparam logic signed [4:0] REW_ONESHOT = 5'sh06;
    localparam logic [3:0] STEP_FIRST = 4'h1;
    localparam logic [3:0] STEP_LAST = 4'h8;
    localparam logic [15:0] TIMER_RESET = 16'h0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    typedef enum logic [1:0] {ST_STOPPED, ST_ALWAYS_ON, ST_PAUSED} srps_state_type;
    typedef struct packed {
        logic permit;
        logic signed [4:0] rewind;
        logic signed [4:0] hold;
        logic signed [4:0] act;
    } srps_cfg_type;
    typedef struct packed {
        logic relay;
        logic transistor;
        logic [15:0] analog;
    } srps_out_type;
    localparam srps_cfg_type CFG_RESET = '{permit: 1'b0, rewind: SEL_NONE, hold: SEL_NONE, act: SEL_NONE};
    localparam srps_out_type OUT_RESET = '{relay: 1'b0, transistor: 1'b0, analog: 16'h0000};
endpackage

// File: rtl/srps_top.sv
// Purpose: Activation, pause, rewind and override control of a step sequencer
// Assumes: APB slave, zero wait states; schedule and motor inputs are on pclk
// Notes: Read data is captured in the setup cycle
//
// Local design decisions: the register addresses and the APB slave port.
module srps_top import srps_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [DI_COUNT-1:0] digital_input,
    input wire logic [TF_COUNT-1:0] schedule_function,
    input wire logic motor_started,
    input wire logic run_permit,
    input wire logic start_request,
    input wire logic step_advance,
    input wire srps_out_type step_values,
    output srps_out_type step_outputs,
    output logic [15:0] step_timer,
    output logic [3:0] current_step_index,
    output logic motor_start,
    output logic sequencer_always_on
);
    function automatic logic srps_di_level(input logic signed [4:0] sel, input logic [DI_COUNT-1:0] di);
        logic r;
        r = 1'b0;
        // Selector codes outside -5..5 fall through as inactive
        for (int i = 0; i < DI_COUNT; i++) begin
            if (int'(sel) == i + 1) begin
                r = di[i];
            end
            if (int'(sel) == -(i + 1)) begin
                r = ~di[i];
            end
        end
        return r;
    endfunction

    // Fields are placed by part-select so a signed code cannot spill into its neighbours
    function automatic logic [31:0] srps_cfg_word(input srps_cfg_type c);
        logic [31:0] w;
        w = RDATA_RESET;
        w[CFG_ACT_POS +: 5] = c.act;
        w[CFG_HOLD_POS +: 5] = c.hold;
        w[CFG_REW_POS +: 5] = c.rewind;
        w[CFG_PERMIT_POS] = c.permit;
        return w;
    endfunction

    function automatic logic [31:0] srps_status_word(input logic [3:0] step, input srps_state_type st,
        input logic motor, input logic [15:0] tmr);
        logic [31:0] w;
        w = RDATA_RESET;
        w[STS_STEP_POS +: 4] = step;
        w[STS_STATE_POS +: 2] = st;
        w[STS_MOTOR_POS] = motor;
        w[STS_TIMER_POS +: 16] = tmr;
        return w;
    endfunction

    function automatic logic [1:0] srps_reg_sel(input logic [11:0] a);
        unique case (a)
            OFS_CFG: return 2'h0;
            OFS_FORCE: return 2'h1;
            OFS_STATUS: return 2'h2;
            default: return 2'h3;
        endcase
    endfunction

    logic [DI_COUNT-1:0] di_meta_q, di_sync_q;
    srps_cfg_type cfg_q, cfg_d;
    logic [3:0] force_val_q, force_val_d;
    logic force_pend_q, force_pend_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    srps_state_type state_q, state_d;
    logic [3:0] step_q, step_d;
    logic [15:0] timer_q, timer_d;
    srps_out_type outs_q, outs_d;
    logic motor_q, motor_d;
    logic always_on_q, always_on_d;
    logic act_lvl, hold_lvl, rew_lvl, setup, access, wr, force_ok, pause_br;
    logic [1:0] rsel;

    // Two flops before any logic sees a digital input pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            di_meta_q <= '0;
            di_sync_q <= '0;
        end else begin
            di_meta_q <= digital_input;
            di_sync_q <= di_meta_q;
        end
    end

    always_comb begin
        act_lvl = srps_di_level(cfg_q.act, di_sync_q);
        if (cfg_q.act == ACT_MOTOR) act_lvl = motor_started;
        for (int i = 0; i < TF_COUNT; i++) begin
            if (int'(cfg_q.act) == int'(ACT_TF_FIRST) + i) act_lvl = schedule_function[i];
        end
        if (cfg_q.act == ACT_ALWAYS) act_lvl = 1'b1;
        hold_lvl = srps_di_level(cfg_q.hold, di_sync_q) | (cfg_q.hold == HOLD_ALWAYS);
        rew_lvl = srps_di_level(cfg_q.rewind, di_sync_q) | (cfg_q.rewind == REW_ONESHOT);
    end

    // Register bus
    always_comb begin
        setup = psel & ~penable;
        access = psel & penable & pready_q;
        wr = access & pwrite;
        rsel = srps_reg_sel(paddr);
        pready_d = setup;
        pslverr_d = setup & (rsel == 2'h3);
        prdata_d = RDATA_RESET;
        if (setup & ~pwrite) begin
            unique case (rsel)
                2'h0: prdata_d = srps_cfg_word(cfg_q);
                2'h1: prdata_d = {28'h000_0000, force_val_q};
                2'h2: prdata_d = srps_status_word(step_q, state_q, motor_q, timer_q);
                2'h3: prdata_d = RDATA_RESET;
            endcase
        end
        cfg_d = cfg_q;
        // One-shot rewind field falls back to none after one cycle
        if (cfg_q.rewind == REW_ONESHOT) cfg_d.rewind = SEL_NONE;
        force_val_d = force_val_q;
        force_pend_d = 1'b0;
        if (wr && rsel == 2'h0) begin
            cfg_d.act = pwdata[CFG_ACT_POS +: 5];
            cfg_d.hold = pwdata[CFG_HOLD_POS +: 5];
            cfg_d.rewind = pwdata[CFG_REW_POS +: 5];
            cfg_d.permit = pwdata[CFG_PERMIT_POS];
        end
        if (wr && rsel == 2'h1) begin
            force_val_d = pwdata[3:0];
            force_pend_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= CFG_RESET;
            force_val_q <= STEP_FIRST;
            force_pend_q <= 1'b0;
            prdata_q <= RDATA_RESET;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            force_val_q <= force_val_d;
            force_pend_q <= force_pend_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Sequencer control; stop paths come first so loss beats pause
    always_comb begin
        state_d = state_q;
        step_d = step_q;
        timer_d = timer_q;
        outs_d = outs_q;
        pause_br = 1'b0;
        force_ok = 1'b0;
        if (!cfg_q.permit) begin
            state_d = ST_STOPPED;
            step_d = STEP_FIRST;
            timer_d = TIMER_RESET;
            outs_d = OUT_RESET;
        end else if (!act_lvl) begin
            state_d = ST_STOPPED;
            timer_d = TIMER_RESET;
            outs_d = OUT_RESET;
            if (rew_lvl) step_d = STEP_FIRST;
        end else if (hold_lvl) begin
            state_d = ST_PAUSED;
            pause_br = 1'b1;
            force_ok = force_pend_q && state_q == ST_PAUSED && force_val_q >= STEP_FIRST && force_val_q <= STEP_LAST;
            if (force_ok) step_d = force_val_q;
        end else begin
            state_d = ST_ALWAYS_ON;
            timer_d = timer_q + 16'h0001;
            outs_d = step_values;
            if (step_advance && state_q == ST_ALWAYS_ON) begin
                step_d = (step_q >= STEP_LAST) ? STEP_FIRST : step_q + 4'h1;
                timer_d = TIMER_RESET;
            end
        end
        motor_d = (state_d == ST_ALWAYS_ON) & start_request & run_permit;
        // Registered copy so the always_on flag leaves a flop, not a decoder
        always_on_d = (state_d == ST_ALWAYS_ON);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_STOPPED;
            step_q <= STEP_FIRST;
            timer_q <= TIMER_RESET;
            outs_q <= OUT_RESET;
            motor_q <= 1'b0;
            always_on_q <= 1'b0;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
            timer_q <= timer_d;
            outs_q <= outs_d;
            motor_q <= motor_d;
            always_on_q <= always_on_d;
        end
    end

    always_comb begin
        prdata = prdata_q;
        pready = pready_q;
        pslverr = pslverr_q;
        step_outputs = outs_q;
        step_timer = timer_q;
        current_step_index = step_q;
        motor_start = motor_q;
        sequencer_always_on = always_on_q;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_stop_clears: assert property (state_q == ST_STOPPED |-> timer_q == TIMER_RESET && outs_q == OUT_RESET)
        else $error("stopped with live timer or outputs");
    a_loss_keeps_step: assert property (cfg_q.permit && !act_lvl && !rew_lvl |=> $stable(step_q))
        else $error("step changed on activation loss");
    a_permit_first: assert property (!cfg_q.permit |=> step_q == STEP_FIRST && state_q == ST_STOPPED)
        else $error("permit loss did not reset step");
    a_rewind_first: assert property (cfg_q.permit && !act_lvl && rew_lvl |=> step_q == STEP_FIRST)
        else $error("rewind did not reach first step");
    a_pause_freeze: assert property (pause_br && state_q == ST_PAUSED |=> $stable(timer_q) && $stable(outs_q))
        else $error("paused timer or outputs moved");
    a_pause_step: assert property (pause_br && !force_ok |=> $stable(step_q))
        else $error("step moved while paused");
    a_force_step: assert property (force_ok |=> step_q == $past(force_val_q))
        else $error("override not applied");
    a_motor_permit: assert property (motor_q |-> $past(run_permit))
        else $error("motor start without run permit");
    a_always_on: assert property (cfg_q.act == ACT_ALWAYS && cfg_q.permit && !hold_lvl |=> state_q == ST_ALWAYS_ON)
        else $error("always-on source not always_on");
    a_none_idle: assert property (cfg_q.act == SEL_NONE |=> state_q == ST_STOPPED)
        else $error("ran with no activation source");
    a_resume_step: assert property (state_q == ST_STOPPED && cfg_q.permit && act_lvl |=> $stable(step_q))
        else $error("activation moved the step");
    a_sync_delay: assert property (##2 di_sync_q == $past(digital_input, 2))
        else $error("input sync latency wrong");
    a_sync_chain: assert property (di_sync_q == $past(di_meta_q))
        else $error("second sync stage skipped");
    a_di_direct: assert property (cfg_q.act == 5'sh01 && !di_sync_q[0] |=> state_q == ST_STOPPED)
        else $error("direct input low still active");
    a_di_inverted: assert property (cfg_q.act == -5'sh01 && di_sync_q[0] |=> state_q == ST_STOPPED)
        else $error("inverted input high still active");
    a_motor_source: assert property (cfg_q.act == ACT_MOTOR && cfg_q.permit && !hold_lvl && motor_started
        |=> state_q == ST_ALWAYS_ON)
        else $error("motor source did not activate");
    a_motor_idle: assert property (cfg_q.act == ACT_MOTOR && !motor_started |=> state_q == ST_STOPPED)
        else $error("motor source active while motor idle");
    a_sched_on: assert property (cfg_q.act == ACT_TF_FIRST && cfg_q.permit && !hold_lvl && schedule_function[0]
        |=> state_q == ST_ALWAYS_ON)
        else $error("schedule source did not activate");
    a_sched_off: assert property (cfg_q.act == ACT_TF_FIRST && !schedule_function[0] |=> state_q == ST_STOPPED)
        else $error("schedule source active while low");
    a_hold_always: assert property (cfg_q.permit && act_lvl && cfg_q.hold == HOLD_ALWAYS |=> state_q == ST_PAUSED)
        else $error("always pause not paused");
    a_hold_direct: assert property (cfg_q.permit && act_lvl && cfg_q.hold == 5'sh01 && di_sync_q[0]
        |=> state_q == ST_PAUSED)
        else $error("direct pause input ignored");
    a_hold_inverted: assert property (cfg_q.permit && act_lvl && cfg_q.hold == -5'sh01 && !di_sync_q[0]
        |=> state_q == ST_PAUSED)
        else $error("inverted pause input ignored");
    a_motor_follow: assert property (state_d == ST_ALWAYS_ON && start_request && run_permit |=> motor_q)
        else $error("permitted start not passed on");
    a_stop_no_motor: assert property (state_q == ST_STOPPED |-> !motor_q)
        else $error("motor start while stopped");
    a_loss_beats_hold: assert property (cfg_q.permit && !act_lvl && hold_lvl
        |=> state_q == ST_STOPPED && timer_q == TIMER_RESET)
        else $error("pause won over activation loss");
    a_rewind_always_on: assert property (state_q == ST_ALWAYS_ON && act_lvl && !hold_lvl && rew_lvl && !step_advance
        |=> $stable(step_q))
        else $error("rewind acted while always_on");
    a_run_outputs: assert property (cfg_q.permit && act_lvl && !hold_lvl |=> outs_q == $past(step_values))
        else $error("always_on outputs not step data");
    // Bus timing guards; a slave that stretches the access would stall the master
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held past access");
    a_slverr_bad: assert property (psel && !penable && rsel == 2'h3 |=> pslverr)
        else $error("unmapped address not refused");
    a_oneshot_clear: assert property (cfg_q.rewind == REW_ONESHOT && !(wr && rsel == 2'h0)
        |=> cfg_q.rewind == SEL_NONE)
        else $error("one-shot rewind stuck");

    c_run: cover property (state_q == ST_STOPPED ##1 state_q == ST_ALWAYS_ON);
    c_pause: cover property (state_q == ST_ALWAYS_ON ##1 state_q == ST_PAUSED);
    c_force: cover property (force_ok);
    c_rewind: cover property (state_q == ST_STOPPED && rew_lvl && step_q != STEP_FIRST);
    c_stop: cover property (state_q == ST_ALWAYS_ON ##1 state_q == ST_STOPPED);
endmodule // srps_top

// File: tb/srps_far_model.sv
// Purpose: Far-side model of digital inputs, schedule functions, motor and step data
// Assumes: Levels requested by the bench are launched at the next rising edge
// Notes: Step data changes every cycle so a frozen output cannot pass by luck
module srps_far_model import srps_pkg::*; (
    input wire logic pclk,
    input wire logic [12:0] want,
    output logic [DI_COUNT-1:0] digital_input,
    output logic [TF_COUNT-1:0] schedule_function,
    output logic motor_started,
    output logic run_permit,
    output logic start_request,
    output logic step_advance,
    output srps_out_type step_values
);
    timeunit 1ns;
    timeprecision 1ns;
    integer sd = 32'h9d0a_ec0d;
    initial begin
        {step_advance, start_request, run_permit, motor_started, schedule_function, digital_input} = '0;
        step_values = '0;
    end
    // Requested levels are launched at each rising edge, with new random step data
    always @(posedge pclk) begin
        {step_advance, start_request, run_permit, motor_started, schedule_function, digital_input} <= want;
        step_values <= srps_out_type'(18'($random(sd)));
    end
endmodule // srps_far_model

// File: tb/test_srps_top.sv
// Purpose: Self-checking bench for the sequencer run/pause source select block
// Assumes: APB slave answers in its own time, inputs settle within five cycles
// Notes: Sequencer outputs are sampled on the falling edge to stay clear of update races; bus replies on the rising edge
module test_srps_top import srps_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [12:0] want;
    logic [DI_COUNT-1:0] digital_input;
    logic [TF_COUNT-1:0] schedule_function;
    logic motor_started, run_permit, start_request, step_advance, motor_start, sequencer_always_on;
    srps_out_type step_values, step_outputs, so;
    logic [15:0] step_timer, t;
    logic [3:0] current_step_index, k;
    integer sd = 32'h9d0a_ec0d;
    int num_errors = 0, tests_run = 0, cyc = 0;
    srps_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .digital_input(digital_input), .schedule_function(schedule_function), .motor_started(motor_started),
        .run_permit(run_permit), .start_request(start_request), .step_advance(step_advance),
        .step_values(step_values), .step_outputs(step_outputs), .step_timer(step_timer),
        .current_step_index(current_step_index), .motor_start(motor_start), .sequencer_always_on(sequencer_always_on));
    srps_far_model far_u (.pclk(pclk), .want(want), .digital_input(digital_input),
        .schedule_function(schedule_function), .motor_started(motor_started), .run_permit(run_permit),
        .start_request(start_request), .step_advance(step_advance), .step_values(step_values));
    initial begin
        pclk = 0;
        forever #50 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Bound on the whole run, far above the few hundred cycles used
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        forever begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic setw(input logic [12:0] v);
        @(posedge pclk);
        want <= v;
    endtask
    function automatic logic [31:0] cfg(input int a, input int h, input int r, input int p);
        return 32'((a & 31) | ((h & 31) << 8) | ((r & 31) << 16) | (p << 24));
    endfunction
    // Expected level of a selector; hold selects only inputs and the always-on code
    function automatic logic lvl(input int s, input logic [12:0] w, input bit hold);
        if (s < 0 && s >= -5) return ~w[-s-1];
        if (s >= 1 && s <= 5) return w[s-1];
        if (s == 6) return hold ? 1'b1 : w[9];
        if (!hold && s >= 7 && s <= 10) return w[s-2];
        return !hold && s == 11;
    endfunction
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        want = 13'h0400;
        presetn = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        cy(0);
        chk(current_step_index, 4'h1);
        apb(0, OFS_CFG, 0);
        chk(rdat, 32'h0000_0000);
        apb(0, 12'h00c, 0);
        chk(rerr, 1'b1);
        for (int s = -6; s <= 12; s++) begin
            for (int n = 0; n < 2; n++) begin
                setw({3'b010, 10'($random(sd))});
                apb(1, OFS_CFG, cfg(s, 0, 0, 1));
                cy(5);
                chk(sequencer_always_on, lvl(s, want, 0));
            end
        end
        for (int s = -5; s <= 6; s++) begin
            setw({3'b010, 10'($random(sd))});
            apb(1, OFS_CFG, cfg(11, s, 0, 1));
            cy(5);
            apb(0, OFS_STATUS, 0);
            chk(rdat[9:8], lvl(s, want, 1) ? 2'd2 : 2'd1);
            cy(0);
            t = step_timer;
            so = step_outputs;
            cy(3);
            if (lvl(s, want, 1)) chk({step_timer, step_outputs}, {t, so});
            else chk(step_timer, t + 16'd3);
        end
        apb(1, OFS_CFG, cfg(11, 0, 0, 1));
        setw(13'h1400);
        cy(3);
        setw(13'h0400);
        cy(2);
        k = current_step_index;
        chk(k == 4'h1, 1'b0);
        apb(1, OFS_CFG, cfg(0, 0, 0, 1));
        cy(2);
        chk({sequencer_always_on, step_outputs, step_timer, current_step_index}, {35'h0, k});
        apb(1, OFS_CFG, cfg(11, 0, 6, 1));
        cy(2);
        chk({sequencer_always_on, current_step_index}, {1'b1, k});
        apb(1, OFS_CFG, cfg(0, 0, 6, 1));
        cy(2);
        chk(current_step_index, 4'h1);
        apb(1, OFS_CFG, cfg(11, 6, 0, 1));
        cy(3);
        apb(1, OFS_FORCE, 5);
        cy(2);
        chk(current_step_index, 4'h5);
        apb(1, OFS_CFG, cfg(11, 0, 0, 1));
        apb(1, OFS_FORCE, 3);
        cy(2);
        chk(current_step_index, 4'h5);
        apb(1, OFS_CFG, cfg(0, 6, 0, 1));
        cy(2);
        chk({step_outputs, step_timer}, 34'h0);
        apb(1, OFS_CFG, cfg(1, 0, -1, 1));
        cy(5);
        chk({sequencer_always_on, current_step_index}, {1'b0, 4'h1});
        apb(1, OFS_CFG, cfg(11, 6, 0, 1));
        cy(3);
        apb(1, OFS_FORCE, 7);
        apb(1, OFS_CFG, cfg(11, 6, 0, 0));
        cy(2);
        chk({sequencer_always_on, current_step_index}, {1'b0, 4'h1});
        apb(1, OFS_CFG, cfg(11, 0, 0, 1));
        setw(13'h0800);
        cy(3);
        chk(motor_start, 1'b0);
        setw(13'h0c00);
        cy(3);
        chk(motor_start, 1'b1);
        tally_and_finish();
    end
endmodule // test_srps_top
